/* rtl/ssrl_consts.svh */
// Constants of the switch state remote link: timing, framing and sizes.
// Overview of operation
// - After reset the encoder sleeps and drives the line low.
// - Any switch line sampled high wakes the encoder and starts a packet.
// - Each packet captures the switch levels, adds redundancy and shifts out serially.
// - Packets repeat back to back while any switch is high, else sleep.
// - Switch levels are resampled at the start of every packet.
// - A started packet always completes even if all switches drop.
// - The decoder idles until a low to high edge on its serial input.
// - Only packets passing every nibble check update the four output lines.
// - A failing packet is dropped and the decoder hunts for the next one.
// - Outputs hold between valid packets; the hold timer restarts with each.
// - After 131 ms with no valid packet all outputs go low.
// - Rate select low gives 2400 bit/s, high gives 9600 bit/s.
// - Switch input n drives remote output n.
`ifndef SSRL_CONSTS_SVH
`define SSRL_CONSTS_SVH
`define SSRL_CLK_HZ 250000000
`define SSRL_BAUD_SLOW 2400
`define SSRL_BAUD_FAST 9600
`define SSRL_HOLD_MS 131
`define SSRL_LINES 4
`define SSRL_FRAME_BITS 19
`define SSRL_DATA_BITS 16
`define SSRL_CNT_W 32
`define SSRL_FIFO_DEPTH 16
`define SSRL_GAP_BITS 2'h0
`define SSRL_RST_LINES 4'h0
`endif

/* rtl/ssrl_pkg.sv */
// Types shared by the switch state remote link.
`default_nettype none
`include "ssrl_consts.svh"
package ssrl_pkg;
  typedef enum logic [0:0] {SSRL_E_SLEEP = 1'b0, SSRL_E_SEND = 1'b1} ssrl_enc_st_t;
  typedef enum logic [0:0] {SSRL_D_IDLE = 1'b0, SSRL_D_RECV = 1'b1} ssrl_dec_st_t;
  typedef struct packed {
    ssrl_enc_st_t est;
    logic ser;
    logic [`SSRL_FRAME_BITS-1:0] eshreg;
    logic [4:0] ebits;
    logic [`SSRL_CNT_W-1:0] ecyc;
    ssrl_dec_st_t dst;
    logic prev;
    logic [`SSRL_CNT_W-1:0] dcyc;
    logic [4:0] dbits;
    logic [`SSRL_DATA_BITS-1:0] dshreg;
    logic push;
    logic [`SSRL_LINES-1:0] pdata;
    logic hold_act;
    logic [`SSRL_CNT_W-1:0] hold_cnt;
    logic [`SSRL_LINES-1:0] lines;
  } ssrl_state_t;
endpackage
`default_nettype wire

/* rtl/ssrl_top.sv */
// Switch state remote link: encoder, decoder and the decoder's update FIFO.
`default_nettype none
`include "ssrl_consts.svh"
module ssrl_fifo #(
  parameter int WIDTH = `SSRL_LINES,
  parameter int DEPTH = `SSRL_FIFO_DEPTH
) (
  // Clock and reset.
  input wire logic sys_clk_i,
  input wire logic resetn_i,
  // Fill side.
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  // Drain side.
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o
);
  localparam int AW = $clog2(DEPTH);
  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] cnt;
  } ssrl_fifo_st_t;
  ssrl_fifo_st_t r, next_r;
  logic wr, rd;

  // Pointers wrap naturally, so the depth must be a power of two.
  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || WIDTH < 1) begin : g_bad
    $error("ssrl_fifo: DEPTH must be a power of two of at least 2");
  end

  // Flags come from the occupancy count so full and empty are exact.
  assign in_ready_o = (r.cnt != (AW+1)'(DEPTH));
  assign out_valid_o = (r.cnt != '0);
  assign out_data_o = r.mem[r.rp];
  assign wr = in_valid_i && in_ready_o;
  assign rd = out_valid_o && out_ready_i;

  // Next state of the FIFO.
  always_comb begin
    next_r = r;
    if (wr) begin
      next_r.mem[r.wp] = in_data_i;
      next_r.wp = r.wp + 1'b1;
    end
    if (rd) begin
      next_r.rp = r.rp + 1'b1;
    end
    if (wr && !rd) begin
      next_r.cnt = r.cnt + 1'b1;
    end else if (rd && !wr) begin
      next_r.cnt = r.cnt - 1'b1;
    end
  end

  // State register.
  always_ff @(posedge sys_clk_i) begin
    if (!resetn_i) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end
endmodule

module ssrl_top
  import ssrl_pkg::*;
#(
  parameter logic [`SSRL_CNT_W-1:0] BIT_CYC_SLOW = `SSRL_CNT_W'(`SSRL_CLK_HZ / `SSRL_BAUD_SLOW),
  parameter logic [`SSRL_CNT_W-1:0] BIT_CYC_FAST = `SSRL_CNT_W'(`SSRL_CLK_HZ / `SSRL_BAUD_FAST),
  parameter logic [`SSRL_CNT_W-1:0] HOLD_CYC = `SSRL_CNT_W'(`SSRL_CLK_HZ / 1000 * `SSRL_HOLD_MS),
  parameter int FIFO_DEPTH = `SSRL_FIFO_DEPTH
) (
  // Clock and reset.
  input wire logic sys_clk_i,
  input wire logic resetn_i,
  // Encoder side.
  input wire logic [`SSRL_LINES-1:0] switch_lines_i,
  input wire logic enc_rate_sel_i,
  output logic ser_o,
  // Decoder side.
  input wire logic ser_i,
  input wire logic dec_rate_sel_i,
  input wire logic upd_ready_i,
  output logic [`SSRL_LINES-1:0] switch_lines_o
);
  ssrl_state_t r, next_r;
  logic [`SSRL_CNT_W-1:0] ebit, dbit;
  logic [`SSRL_DATA_BITS-1:0] rx;
  logic chk_ok, last_smp, f_ready, f_valid;
  logic [`SSRL_LINES-1:0] f_data;

  // The bit counters need at least a few cycles to find a centre.
  if (BIT_CYC_SLOW < 4 || BIT_CYC_FAST < 4 || HOLD_CYC < 1) begin : g_bad
    $error("ssrl_top: bit and hold counts too small");
  end

  // shared frame format: start bit, data with complement twice, then two low gap bits.
  function automatic logic [`SSRL_FRAME_BITS-1:0] build(input logic [`SSRL_LINES-1:0] d);
    return {1'b1, d, ~d, d, ~d, `SSRL_GAP_BITS};
  endfunction

  assign ebit = enc_rate_sel_i ? BIT_CYC_FAST : BIT_CYC_SLOW;
  assign dbit = dec_rate_sel_i ? BIT_CYC_FAST : BIT_CYC_SLOW;
  assign rx = {r.dshreg[`SSRL_DATA_BITS-2:0], ser_i};
  assign chk_ok = (rx[15:12] == ~rx[11:8]) && (rx[7:4] == ~rx[3:0]) && (rx[15:12] == rx[7:4]);
  assign last_smp = (r.dst == SSRL_D_RECV) && (r.dcyc == '0) && (r.dbits == 5'h1);

  // Valid packets queue here, up to FIFO_DEPTH; one arriving while the FIFO is full is dropped.
  ssrl_fifo #(.WIDTH(`SSRL_LINES), .DEPTH(FIFO_DEPTH)) u_fifo (
    .sys_clk_i(sys_clk_i),
    .resetn_i(resetn_i),
    .in_valid_i(r.push),
    .in_ready_o(f_ready),
    .in_data_i(r.pdata),
    .out_valid_o(f_valid),
    .out_ready_i(upd_ready_i),
    .out_data_o(f_data)
  );

  // Next state of encoder, decoder and output hold stage.
  always_comb begin
    next_r = r;
    next_r.prev = ser_i;
    next_r.push = 1'b0;
    case (r.est)
      SSRL_E_SLEEP: begin
        next_r.ser = 1'b0;
        // wake when any line is high.
        if (|switch_lines_i) begin
          next_r.est = SSRL_E_SEND;
          next_r.ser = 1'b1;
          next_r.eshreg = build(switch_lines_i) << 1;
          next_r.ebits = 5'(`SSRL_FRAME_BITS - 1);
          next_r.ecyc = ebit - 1'b1;
        end
      end
      SSRL_E_SEND: begin
        if (r.ecyc != '0) begin
          next_r.ecyc = r.ecyc - 1'b1;
        end else if (r.ebits != '0) begin
          // shift out, no exit mid packet.
          next_r.ser = r.eshreg[`SSRL_FRAME_BITS-1];
          next_r.eshreg = r.eshreg << 1;
          next_r.ebits = r.ebits - 1'b1;
          next_r.ecyc = ebit - 1'b1;
        end else if (|switch_lines_i) begin
          next_r.ser = 1'b1;
          next_r.eshreg = build(switch_lines_i) << 1;
          next_r.ebits = 5'(`SSRL_FRAME_BITS - 1);
          next_r.ecyc = ebit - 1'b1;
        end else begin
          next_r.est = SSRL_E_SLEEP;
          next_r.ser = 1'b0;
        end
      end
      default: next_r.est = SSRL_E_SLEEP;
    endcase
    case (r.dst)
      SSRL_D_IDLE: begin
        // start at a rising edge; first sample mid data bit.
        if (ser_i && !r.prev) begin
          next_r.dst = SSRL_D_RECV;
          next_r.dcyc = dbit + (dbit >> 1) - 1'b1;
          next_r.dbits = 5'(`SSRL_DATA_BITS);
        end
      end
      SSRL_D_RECV: begin
        if (r.dcyc != '0) begin
          next_r.dcyc = r.dcyc - 1'b1;
        end else begin
          next_r.dshreg = rx;
          next_r.dbits = r.dbits - 1'b1;
          next_r.dcyc = dbit - 1'b1;
          if (r.dbits == 5'h1) begin
            // push only checked packets, else drop.
            next_r.dst = SSRL_D_IDLE;
            next_r.push = chk_ok && f_ready;
            next_r.pdata = rx[15:12];
          end
        end
      end
      default: next_r.dst = SSRL_D_IDLE;
    endcase
    if (f_valid && upd_ready_i) begin
      next_r.lines = f_data;
      next_r.hold_act = 1'b1;
      next_r.hold_cnt = HOLD_CYC - 1'b1;
    end else if (r.hold_act) begin
      if (r.hold_cnt == '0) begin
        next_r.lines = `SSRL_RST_LINES;
        next_r.hold_act = 1'b0;
      end else begin
        next_r.hold_cnt = r.hold_cnt - 1'b1;
      end
    end
  end

  // State register; reset lands in sleep.
  always_ff @(posedge sys_clk_i) begin
    if (!resetn_i) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  assign ser_o = r.ser;
  assign switch_lines_o = r.lines;

  // Checks of encoder, decoder and hold behaviour.
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!resetn_i);
  sleep_quiet_a: assert property (r.est == SSRL_E_SLEEP |-> !ser_o) else $error("line high in sleep");
  wake_start_a: assert property (
    (r.est == SSRL_E_SLEEP && |switch_lines_i) |=> (ser_o && r.est == SSRL_E_SEND)) else $error("no wake");
  frame_capture_a: assert property (
    (r.est == SSRL_E_SLEEP && |switch_lines_i) |=>
    (r.eshreg[18:15] == $past(switch_lines_i) && r.eshreg[14:11] == ~$past(switch_lines_i)))
    else $error("bad capture");
  sleep_return_a: assert property (
    (r.est == SSRL_E_SEND && r.ecyc == '0 && r.ebits == '0 && switch_lines_i == '0) |=>
    (r.est == SSRL_E_SLEEP && !ser_o)) else $error("no return to sleep");
  repeat_send_a: assert property (
    (r.est == SSRL_E_SEND && r.ecyc == '0 && r.ebits == '0 && |switch_lines_i) |=>
    (ser_o && r.eshreg[18:15] == $past(switch_lines_i))) else $error("no repeat");
  finish_pkt_a: assert property ((r.est == SSRL_E_SEND && r.ebits != '0) |=> r.est == SSRL_E_SEND)
    else $error("packet cut");
  rise_start_a: assert property ((r.dst == SSRL_D_IDLE && ser_i && !r.prev) |=> r.dst == SSRL_D_RECV)
    else $error("edge missed");
  good_push_a: assert property (
    (last_smp && chk_ok && f_ready) |=> (r.push && r.pdata == $past(rx[15:12]))) else $error("good packet lost");
  bad_drop_a: assert property ((last_smp && !chk_ok) |=> !r.push) else $error("bad packet pushed");
  hold_stable_a: assert property (
    (r.hold_act && r.hold_cnt != '0 && !(f_valid && upd_ready_i)) |=> $stable(switch_lines_o))
    else $error("output moved");
  expire_low_a: assert property (
    (r.hold_act && r.hold_cnt == '0 && !(f_valid && upd_ready_i)) |=> (switch_lines_o == '0 && !r.hold_act))
    else $error("no expiry");
  bit_rate_a: assert property (
    (r.est == SSRL_E_SEND && r.ecyc == '0 && r.ebits != '0) |=>
    r.ecyc == ($past(enc_rate_sel_i) ? BIT_CYC_FAST : BIT_CYC_SLOW) - 1'b1) else $error("bad period");
  wake_c: cover property (r.est == SSRL_E_SLEEP ##1 r.est == SSRL_E_SEND);
  push_c: cover property (r.push);
  expire_c: cover property (r.hold_act ##1 !r.hold_act);
  drop_c: cover property (last_smp && !chk_ok);
endmodule
`default_nettype wire

/* tb/ssrl_far_dec.sv */
// Far end decoder model that checks the frames sent by the encoder.
`default_nettype none
module ssrl_far_dec #(
  parameter int SLOW = 16,
  parameter int FAST = 8
) (
  // Link side.
  input wire logic sys_clk_i,
  input wire logic ser_i,
  input wire logic rate_i,
  // Results.
  output logic [3:0] data_o,
  output int frames_o,
  output int bad_frames_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [18:0] sh;
  int b;
  // A high level after idle opens a frame; each bit is taken mid period.
  initial begin
    frames_o = 0;
    bad_frames_o = 0;
    data_o = 4'h0;
    forever begin
      @(posedge sys_clk_i iff ser_i === 1'b1);
      b = rate_i ? FAST : SLOW;
      repeat (b / 2) @(posedge sys_clk_i);
      for (int i = 0; i < 19; i++) begin
        sh = {sh[17:0], ser_i};
        if (i < 18) repeat (b) @(posedge sys_clk_i);
      end
      if (sh !== {1'b1, sh[17:14], ~sh[17:14], sh[17:14], ~sh[17:14], 2'h0}) bad_frames_o++;
      data_o = sh[17:14];
      frames_o++;
    end
  end
endmodule
`default_nettype wire

/* tb/testbench.sv */
// Self-checking bench for the switch state remote link.
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int BS = 16;
  localparam int BF = 8;
  localparam int HOLD = 2000;
  logic sys_clk_i = 1'b0;
  logic resetn_i = 1'b0;
  // idle switch inputs are held low.
  logic [3:0] sw = 4'h0;
  logic rate = 1'b0;
  logic rdy = 1'b1;
  logic loop = 1'b1;
  logic tb_ser = 1'b0;
  logic ser_o;
  logic [3:0] lines;
  logic [3:0] far_data;
  int far_frames;
  int far_bad;
  int fails = 0;
  int tests_run = 0;
  wire logic ser_in = loop ? ser_o : tb_ser;
  // Rows hold rate, switch levels and the remote level they should give.
  logic [8:0] rows [6] = '{9'h111, 9'h022, 9'h144, 9'h088, 9'h1FF, 9'h0AA};

  // Clock of 4 ns period.
  always #2 sys_clk_i = ~sys_clk_i;

  // one rate level feeds both ends, so their bit periods always match.
  ssrl_top #(.BIT_CYC_SLOW(BS), .BIT_CYC_FAST(BF), .HOLD_CYC(HOLD), .FIFO_DEPTH(16)) i_ssrl_top (
    .sys_clk_i(sys_clk_i), .resetn_i(resetn_i), .switch_lines_i(sw), .enc_rate_sel_i(rate), .ser_o(ser_o),
    .ser_i(ser_in), .dec_rate_sel_i(rate), .upd_ready_i(rdy), .switch_lines_o(lines));
  ssrl_far_dec #(.SLOW(BS), .FAST(BF)) i_ssrl_far_dec (.sys_clk_i(sys_clk_i), .ser_i(ser_o),
    .rate_i(rate), .data_o(far_data), .frames_o(far_frames), .bad_frames_o(far_bad));

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected at %0t: saw %0h, wanted %0h", $time, seen, exp);
    end
  endtask

  task automatic stop_test();
    $display("Checks %0d, mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic cyc(input int n);
    repeat (n) @(negedge sys_clk_i);
  endtask

  // Waits, with a bound, until the far end has seen n more frames.
  task automatic frames(input int n);
    int t;
    t = far_frames + n;
    for (int k = 0; k < 20000 && far_frames < t; k++) @(negedge sys_clk_i);
    // A wait that runs out means the encoder stopped repeating, so it counts as a mismatch.
    if (far_frames < t) check(far_frames, t);
  endtask

  // shared frame layout; bad flips a copy bit so the duplicate check fails.
  task automatic send(input logic [3:0] d, input logic bad);
    logic [18:0] f;
    f = {1'b1, d, ~d, d, ~d, 2'h0};
    f[9] = f[9] ^ bad;
    for (int i = 18; i >= 0; i--) begin
      tb_ser = f[i];
      cyc(BS);
    end
  endtask

  // Main sequence; rate only changes while the link sleeps, as both ends read it bit by bit.
  initial begin
    cyc(10);
    resetn_i = 1'b1;
    cyc(400);
    check(ser_o, 0);
    check(lines, 0);
    foreach (rows[r]) begin
      rate = rows[r][8];
      sw = rows[r][7:4];
      frames(2);
      check(far_data, rows[r][3:0]);
      check(lines, rows[r][3:0]);
      sw = 4'h0;
      cyc(HOLD + 300);
      check(lines, 0);
      check(ser_o, 0);
    end
    rate = 1'b1;
    sw = 4'h3;
    frames(1);
    cyc(5 * BF);
    sw = 4'h5;
    frames(1);
    check(far_data, 4'h3);
    cyc(2 * BF);
    sw = 4'h0;
    frames(1);
    check(far_data, 4'h5);
    cyc(40 * BF);
    check(ser_o, 0);
    check(lines, 4'h5);
    check(far_bad, 0);
    rate = 1'b0;
    loop = 1'b0;
    send(4'h6, 1'b0);
    check(lines, 4'h6);
    send(4'h9, 1'b1);
    check(lines, 4'h6);
    send(4'hC, 1'b0);
    check(lines, 4'hC);
    cyc(HOLD - 200);
    check(lines, 4'hC);
    cyc(300);
    check(lines, 0);
    rdy = 1'b0;
    for (int i = 0; i < 17; i++) send(i[3:0], 1'b0);
    check(lines, 0);
    rdy = 1'b1;
    cyc(60);
    check(lines, 4'hF);
    loop = 1'b1;
    sw = 4'hF;
    cyc(50);
    resetn_i = 1'b0;
    sw = 4'h0;
    cyc(2);
    check(ser_o, 0);
    check(lines, 0);
    stop_test();
  end

  // Watchdog set well above the expected run of about 26000 cycles.
  initial begin
    #300000;
    fails++;
    stop_test();
  end
endmodule
`default_nettype wire
